// [verilog/cbap_cfg.svh]
// How it works
// R1: Bit-20 mask clears physical address bit 20
// R2: Drive cycle address on lines 31..3
// R3: Special cycles put definition on address lines
// R4: Inquire samples lines 31..5 only
// R5: Strobe starts cycle, address valid same edge
// R6: Duplicate strobe mirrors primary strobe exactly
// R7: System asserts hold, then drives inquire address
// R8: Float address and parity when hold sampled
// R9: Other outputs keep driving during hold
// R10: Even parity over lines 31..5 plus parity
// R11: Bits 4 and 3 excluded from parity
// R12: Parity mismatch on inquire pulses error one clock
// R13: Resume address drive before next cycle
`ifndef CBAP_CFG_SVH
`define CBAP_CFG_SVH
`define CBAP_MASK_BIT 20
`define CBAP_ADDR_HI 31
`define CBAP_ADDR_LO 3
`define CBAP_PAR_LO 5
`define CBAP_STROBE_CYCLES 1
// Mask synchroniser leaves reset at the pin's idle (high) level, so no false mask
`define CBAP_MASK_SYNC_RST 2'h3
`endif

// [verilog/cbap_pkg.sv]
package cbap_pkg;
    // Physical address lines 31..3
    typedef logic [28:0] cbap_addr_t;
    // Cycle request from the core side
    typedef struct packed {
        logic valid;          // Start a bus cycle
        logic special;        // Special cycle, definition on address lines
        cbap_addr_t addr;     // Address or cycle definition
    } cbap_req_s;
    // Address bus pin group
    typedef struct packed {
        cbap_addr_t addr_o;
        cbap_addr_t addr_oe;
        logic par_o;
        logic par_oe;
    } cbap_pins_s;
    typedef enum logic [1:0] {CBAP_IDLE, CBAP_HOLD, CBAP_RESUME} cbap_state_e;
endpackage

// [verilog/cbap_parity.sv]
`timescale 1ns/10ps
`include "cbap_cfg.svh"
// Even parity over the cache-line part of the address
module cbap_parity
    import cbap_pkg::*;
(
    input wire cbap_addr_t i_addr,
    output logic o_par
);
    // Lines 4 and 3 left out, they do not select a line [R11]
    always_comb begin
        o_par = ^i_addr[`CBAP_ADDR_HI-`CBAP_ADDR_LO:`CBAP_PAR_LO-`CBAP_ADDR_LO]; // [R10]
    end
endmodule

// [verilog/cbap_top.sv]
`timescale 1ns/10ps
`include "cbap_cfg.svh"
// Address phase of the external bus: drive, hold/inquire, parity
module cbap_top
    import cbap_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire cbap_req_s i_req,            // Core cycle request, same clock
    output logic o_req_ready,               // Request taken this cycle
    input wire logic i_addr_bit20_mask_n,   // Pin, synchronised
    input wire logic i_addr_bus_hold_req,   // Pin, synchronised
    input wire cbap_addr_t i_addr,          // Address lines as seen on the bus
    input wire logic i_addr_parity_bit,     // Parity pin as seen on the bus
    output cbap_addr_t o_addr,
    output cbap_addr_t o_addr_oe,
    output logic o_addr_parity_bit,
    output logic o_addr_parity_bit_oe,
    output logic o_cycle_start_strobe_n,
    output logic o_cycle_start_strobe_dup_n,
    output logic o_addr_parity_err_n,
    output logic o_inq_valid,               // Sampled inquire address valid
    output cbap_addr_t o_inq_addr           // Inquire address, lines 4..3 zero
);
    // Whole module state in one struct
    typedef struct packed {
        logic [1:0] mask_sync;
        logic [1:0] hold_sync;
        cbap_state_e st;
        cbap_pins_s pins;
        logic ads_n;
        logic ads_dup_n;
        logic perr_n;
        logic ready;
        logic inq_valid;
        cbap_addr_t inq_addr;
    } cbap_st_s;

    cbap_st_s s_q, s_d;
    cbap_addr_t phys_addr;    // Address after bit-20 masking
    logic gen_par;            // Parity for outgoing address
    logic chk_par;            // Parity over sampled address
    logic hold;               // Synchronised hold request
    logic mask_on;            // Synchronised mask request

    assign hold = s_q.hold_sync[1];
    assign mask_on = ~s_q.mask_sync[1];

    // Masking only touches real addresses, special cycle codes pass through
    always_comb begin
        phys_addr = i_req.addr;
        if (mask_on && !i_req.special) begin
            phys_addr[`CBAP_MASK_BIT-`CBAP_ADDR_LO] = 1'b0; // [R1]
        end
    end

    cbap_parity u_gen (
        .i_addr(phys_addr),
        .o_par(gen_par)
    );

    cbap_parity u_chk (
        .i_addr(i_addr),
        .o_par(chk_par)
    );

    // Next state
    always_comb begin
        s_d = s_q;
        s_d.mask_sync = {s_q.mask_sync[0], i_addr_bit20_mask_n};
        s_d.hold_sync = {s_q.hold_sync[0], i_addr_bus_hold_req};
        s_d.ads_n = 1'b1;
        s_d.ads_dup_n = 1'b1;
        s_d.perr_n = 1'b1;
        s_d.ready = 1'b0;
        s_d.inq_valid = 1'b0;
        case (s_q.st)
            CBAP_IDLE: begin
                if (hold) begin
                    // Release address and parity on the hold edge [R8]
                    s_d.pins.addr_oe = '0;
                    s_d.pins.par_oe = 1'b0;
                    s_d.st = CBAP_HOLD;
                end else if (i_req.valid && !s_q.ready) begin
                    // Address, parity and both strobes on one edge [R5]
                    s_d.pins.addr_o = phys_addr; // [R2] [R3]
                    s_d.pins.par_o = gen_par; // [R10]
                    s_d.ads_n = 1'b0;
                    s_d.ads_dup_n = 1'b0; // [R6]
                    s_d.ready = 1'b1;
                end
            end
            CBAP_HOLD: begin
                // Strobes and error output still driven here [R9]
                // System owns the bus now [R7]
                s_d.inq_valid = 1'b1;
                s_d.inq_addr = {i_addr[28:2], 2'b00}; // [R4]
                if (chk_par != i_addr_parity_bit) begin
                    s_d.perr_n = 1'b0; // [R12]
                end
                if (!hold) begin
                    s_d.inq_valid = 1'b0;
                    s_d.perr_n = 1'b1;
                    s_d.st = CBAP_RESUME;
                end
            end
            CBAP_RESUME: begin
                // One cycle of drive before any new strobe [R13]
                s_d.pins.addr_oe = '1;
                s_d.pins.par_oe = 1'b1;
                s_d.st = CBAP_IDLE;
            end
            default: begin
                s_d.st = CBAP_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            s_q <= '0;
            s_q.mask_sync <= `CBAP_MASK_SYNC_RST;
            s_q.st <= CBAP_IDLE;
            s_q.pins.addr_oe <= '1;
            s_q.pins.par_oe <= 1'b1;
            s_q.ads_n <= 1'b1;
            s_q.ads_dup_n <= 1'b1;
            s_q.perr_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_req_ready = s_q.ready;
    assign o_addr = s_q.pins.addr_o;
    assign o_addr_oe = s_q.pins.addr_oe;
    assign o_addr_parity_bit = s_q.pins.par_o;
    assign o_addr_parity_bit_oe = s_q.pins.par_oe;
    assign o_cycle_start_strobe_n = s_q.ads_n;
    assign o_cycle_start_strobe_dup_n = s_q.ads_dup_n;
    assign o_addr_parity_err_n = s_q.perr_n;
    assign o_inq_valid = s_q.inq_valid;
    assign o_inq_addr = s_q.inq_addr;

    // Strobe copy never differs from the primary
    a_strobe_dup_match: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R6]
        o_cycle_start_strobe_n == o_cycle_start_strobe_dup_n)
        else $error("duplicate strobe differs");
    // Strobe only while address driven
    a_strobe_drive: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R5]
        !o_cycle_start_strobe_n |-> (o_addr_oe == '1 && o_addr_parity_bit_oe))
        else $error("strobe without address drive");
    // Parity matches driven address on strobe
    a_parity_gen: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R10]
        !o_cycle_start_strobe_n |-> (^o_addr[28:2] == o_addr_parity_bit))
        else $error("bad generated parity");
    // Masked bit 20 on real cycles
    a_mask_bit20: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R1]
        (i_req.valid && !i_req.special && mask_on && s_q.st == CBAP_IDLE && !hold && !s_q.ready)
        |=> !o_addr[`CBAP_MASK_BIT-`CBAP_ADDR_LO])
        else $error("bit 20 not masked");
    // Float on next edge after hold seen idle
    a_hold_float: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R8]
        (hold && s_q.st == CBAP_IDLE) |=> (o_addr_oe == '0 && !o_addr_parity_bit_oe))
        else $error("bus not floated on hold");
    // Parity error clears on the next clock unless the inquire sample is still valid
    a_perr_pulse: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R12]
        $fell(o_addr_parity_err_n) |=> o_addr_parity_err_n || o_inq_valid)
        else $error("parity error stuck");
    // Parity error only while an inquire sample is valid
    a_perr_cause: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R12]
        !o_addr_parity_err_n |-> o_inq_valid)
        else $error("parity error outside inquire");
    // Inquire address low lines zero
    a_inq_low: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R4]
        o_inq_valid |-> o_inq_addr[1:0] == 2'b00)
        else $error("low inquire lines sampled");
    // Drive returns, with strobes still quiet, once the inquire ends
    a_resume: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R13]
        $fell(o_inq_valid) |=> (o_addr_oe == '1 && o_addr_parity_bit_oe && o_cycle_start_strobe_n))
        else $error("no resume drive");
    // Ready and strobe are one and the same event
    a_ready_strobe: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R5]
        o_req_ready == !o_cycle_start_strobe_n)
        else $error("ready and strobe differ");
    // A taken request never starts a second cycle on the next edge
    a_ready_pulse: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R5]
        o_req_ready |=> !o_req_ready)
        else $error("ready longer than one clock");
    // No cycle starts while the address bus is given away
    a_strobe_idle: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R8]
        !o_cycle_start_strobe_n |-> s_q.st == CBAP_IDLE)
        else $error("strobe outside idle");
    // Address stands past the strobe for the far side to latch
    a_addr_stands: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R2]
        !o_cycle_start_strobe_n |=> $stable(o_addr))
        else $error("address moved after strobe");
    // Bus stays floated for the whole hold
    a_float_holds: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R8]
        (s_q.st == CBAP_HOLD) |-> (o_addr_oe == '0 && !o_addr_parity_bit_oe))
        else $error("bus driven during hold");
    // Every held cycle yields an inquire sample
    a_inq_sample: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R4]
        (s_q.st == CBAP_HOLD && hold) |=> o_inq_valid)
        else $error("inquire not sampled");
    // Odd count of ones on lines 31..5 plus parity flags an error
    a_perr_detect: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R12]
        (s_q.st == CBAP_HOLD && hold && (^i_addr[28:2] != i_addr_parity_bit)) |=> !o_addr_parity_err_n)
        else $error("parity error missed");
    // Even count stays quiet, whatever lines 4..3 carry
    a_perr_quiet: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R11]
        (s_q.st == CBAP_HOLD && hold && (^i_addr[28:2] == i_addr_parity_bit)) |=> o_addr_parity_err_n)
        else $error("false parity error");
    // Resume cycle hands the address lines back to the device
    a_resume_drive: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R13]
        (s_q.st == CBAP_RESUME) |=> (o_addr_oe == '1 && o_addr_parity_bit_oe))
        else $error("drive not resumed");

    c_cycle: cover property (@(posedge i_clk_sys) !o_cycle_start_strobe_n);
    c_inquire: cover property (@(posedge i_clk_sys) o_inq_valid);
    c_perr: cover property (@(posedge i_clk_sys) !o_addr_parity_err_n);
    c_masked: cover property (@(posedge i_clk_sys) mask_on && i_req.valid);
    c_resume: cover property (@(posedge i_clk_sys) s_q.st == CBAP_RESUME);
endmodule

// [sim/cbap_chipset_model.sv]
`timescale 1ns/10ps
// Chipset side: asks for the bus, then drives the inquire address
module cbap_chipset_model
    import cbap_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_hold_cmd,        // Start an inquire
    input wire cbap_addr_t i_inq_addr,  // Address to snoop
    input wire logic i_bad_par,         // Corrupt parity on purpose
    input wire cbap_addr_t i_dev_addr,
    input wire cbap_addr_t i_dev_addr_oe,
    input wire logic i_dev_par,
    input wire logic i_dev_par_oe,
    output logic o_hold_req,
    output cbap_addr_t o_wire_addr,
    output logic o_wire_par
);
    logic drv_q = 1'b0;         // Drives only once the device has let go
    cbap_addr_t last_q = '0;    // Undriven lines show the inverse of this
    logic last_par_q = 1'b0;
    cbap_addr_t own_m;          // Lines this side drives
    assign o_hold_req = i_hold_cmd;
    // Lines 4..3 never driven from here, so they float as noise
    assign own_m = {{27{drv_q}}, 2'b00};
    assign o_wire_addr = (i_dev_addr & i_dev_addr_oe)
        | (~i_dev_addr_oe & ((own_m & i_inq_addr) | (~own_m & ~last_q)));
    // Even parity over lines 31..5 only
    assign o_wire_par = i_dev_par_oe ? i_dev_par : drv_q ? (^i_inq_addr[28:2]) ^ i_bad_par : ~last_par_q;
    // Contention avoided: take the bus one edge after the float
    always @(posedge i_clk_sys) begin
        drv_q <= i_hold_cmd && i_dev_addr_oe == '0 && !i_dev_par_oe;
        last_q <= o_wire_addr;
        last_par_q <= o_wire_par;
    end
endmodule

// [sim/cbap_top_tb_top.sv]
`timescale 1ns/10ps
// Bench for the address phase: requests, mask, inquire, parity
module cbap_top_tb_top
    import cbap_pkg::*;
;
    typedef struct packed {logic mask_n; logic special; cbap_addr_t addr; cbap_addr_t exp;} cbap_row_s;
    logic clk = 0, rst = 1, mask_n = 1, hold_cmd = 0, bad_par = 0;
    logic hold, w_par, ready, par, par_oe, stb_n, dup_n, err_n, inq_v;
    cbap_req_s req = '0;
    cbap_addr_t inq = 29'h0abc_def0, w_addr, o_addr, oe, inq_addr;
    int n_errors = 0, check_count = 0, k, cnt;
    // Mask on/off, special cycles skip the mask
    cbap_row_s rows [5] = '{'{1'b0, 1'b0, 29'h1fff_ffff, 29'h1ffd_ffff}, '{1'b1, 1'b0, 29'h0002_0003, 29'h0002_0003},
        '{1'b0, 1'b0, 29'h0002_0004, 29'h0000_0004}, '{1'b0, 1'b1, 29'h0002_0005, 29'h0002_0005},
        '{1'b1, 1'b1, 29'h0000_0000, 29'h0000_0000}};
    cbap_top i_dut (.i_clk_sys(clk), .i_sys_rst(rst), .i_req(req), .o_req_ready(ready),
        .i_addr_bit20_mask_n(mask_n), .i_addr_bus_hold_req(hold), .i_addr(w_addr), .i_addr_parity_bit(w_par),
        .o_addr(o_addr), .o_addr_oe(oe), .o_addr_parity_bit(par), .o_addr_parity_bit_oe(par_oe),
        .o_cycle_start_strobe_n(stb_n), .o_cycle_start_strobe_dup_n(dup_n), .o_addr_parity_err_n(err_n),
        .o_inq_valid(inq_v), .o_inq_addr(inq_addr));
    cbap_chipset_model i_chip (.i_clk_sys(clk), .i_hold_cmd(hold_cmd), .i_inq_addr(inq), .i_bad_par(bad_par),
        .i_dev_addr(o_addr), .i_dev_addr_oe(oe), .i_dev_par(par), .i_dev_par_oe(par_oe), .o_hold_req(hold),
        .o_wire_addr(w_addr), .o_wire_par(w_par));
    // Free-running bus clock, 100 ns
    initial begin
        forever #50 clk = ~clk;
    end
    // Compare and count
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic give_verdict();
        if (n_errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Inputs always move 1 ns after the edge
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    // Wait for the held request to start a cycle, then check it
    task automatic take(input cbap_addr_t exp);
        int n;
        for (n = 0; n < 20 && ready !== 1'b1; n++) tick();
        if (n == 20) begin
            chk("take timeout", 0, 1);
            return;
        end
        chk("strobes", {stb_n, dup_n}, 2'h0);
        chk("address", o_addr, exp);
        chk("parity", par, ^exp[28:2]);
        chk("drive", {oe, par_oe}, 30'h3fff_ffff);
        req.valid = 1'b0;
        tick();
        chk("strobes end", {stb_n, dup_n}, 2'h3);
    endtask
    initial begin
        repeat (4) tick();
        chk("reset flags", {stb_n, dup_n, err_n, ready, inq_v}, 5'h1c);
        chk("reset drive", {oe, par_oe}, 30'h3fff_ffff);
        chk("reset addr", o_addr, 29'h0);
        rst = 0;
        // Ordinary cycles, mask given time to pass its synchroniser
        foreach (rows[i]) begin
            mask_n = rows[i].mask_n;
            repeat (3) tick();
            req = '{1'b1, rows[i].special, rows[i].addr};
            take(rows[i].exp);
        end
        // Inquire: float, refuse a request, sample, parity error
        hold_cmd = 1;
        for (k = 0; k < 10 && oe !== 29'h0; k++) tick();
        chk("float delay", k, 3);
        chk("float", {oe, par_oe}, 30'h0);
        chk("others driven", {stb_n, dup_n, err_n}, 3'h7);
        req = '{1'b1, 1'b0, 29'h0012_3458};
        repeat (3) tick();
        chk("inquire valid", inq_v, 1);
        chk("inquire addr", inq_addr, {inq[28:2], 2'b00});
        chk("good parity", err_n, 1);
        chk("refused", ready, 0);
        bad_par = 1;
        tick();
        bad_par = 0;
        cnt = 0;
        repeat (4) begin
            if (err_n === 1'b0) cnt++;
            tick();
        end
        chk("error pulse", cnt, 1);
        hold_cmd = 0;
        take(29'h0012_3458);
        // Reset in mid-inquire: drive returns, hold is re-synchronised from scratch
        hold_cmd = 1;
        for (k = 0; k < 10 && oe !== 29'h0; k++) tick();
        chk("float again", k, 3);
        rst = 1;
        repeat (4) tick();
        chk("mid reset drive", {oe, par_oe}, 30'h3fff_ffff);
        chk("mid reset flags", {stb_n, dup_n, err_n, ready, inq_v}, 5'h1c);
        rst = 0;
        tick();
        chk("hold resync", {oe, inq_v}, {29'h1fff_ffff, 1'b0});
        for (k = 0; k < 10 && oe !== 29'h0; k++) tick();
        chk("float after reset", k, 2);
        hold_cmd = 0;
        give_verdict();
    end
endmodule
